// File: hw/qps_consts.svh
/*
 * Named constants of the packet priority classifier and egress scheduler:
 * register offsets, field positions, reset values and header offsets.
 * Assumes it is included by bare name inside design and bench files.
 */
`ifndef QPS_CONSTS_SVH
`define QPS_CONSTS_SVH

// ==========================================================================
// register word offsets (byte address is four times the offset)
`define QPS_OFF_CTRL 8'h00
`define QPS_OFF_QMAP 8'h01
`define QPS_OFF_WGT 8'h02
`define QPS_OFF_DSEN 8'h03
`define QPS_OFF_STAT 8'h04
`define QPS_OFF_PPRI 8'h10
`define QPS_OFF_DMAP 8'h40
`define QPS_DMAP_SEL 2'h1

// ==========================================================================
// field positions
`define QPS_CTRL_CLS 1:0
`define QPS_CTRL_SCH 3:2
`define QPS_PPRI_EN 3
`define QPS_PPRI_LVL 2:0
`define QPS_TOS_DSCP 7:2
`define QPS_PCP 7:5

// ==========================================================================
// reset values
`define QPS_RST_CLS 2'h0
`define QPS_RST_SCH 2'h2
`define QPS_RST_QMAP 16'h05AF
`define QPS_RST_WGT 16'h1248
`define QPS_RST_DSEN 10'h3FF

// ==========================================================================
// sizes
`define QPS_NQ 4
`define QPS_NPRIO 8
`define QPS_NPORT 10
`define QPS_NDSCP 64
`define QPS_QAW 4
`define QPS_QDEPTH 5'h10
`define QPS_TAGW 8
`define QPS_SEQW 7

// ==========================================================================
// frame header byte offsets and values
`define QPS_B_ETYPE 5'h0D
`define QPS_B_PCP 5'h0E
`define QPS_B_ETYPE_T 5'h11
`define QPS_B_TOS 5'h0F
`define QPS_B_TOS_T 5'h13
`define QPS_B_LAST 5'h1F
`define QPS_ET_VLAN 16'h8100
`define QPS_ET_IPV4 16'h0800

`endif

// File: hw/qps_pkg.sv
/*
 * Types of the packet priority classifier and egress scheduler.
 * Assumes nothing of its surroundings.
 */
package qps_pkg;

  typedef enum logic [1:0] {
    QPS_CLS_TAG = 2'h0,
    QPS_CLS_DSCP = 2'h1,
    QPS_CLS_PORT = 2'h2
  } qps_cls_t;

  typedef enum logic [1:0] {
    QPS_SCH_FCFS = 2'h0,
    QPS_SCH_STRICT = 2'h1,
    QPS_SCH_WRR = 2'h2
  } qps_sch_t;

  typedef enum logic [2:0] {
    QPS_ST_PICK = 3'h1,
    QPS_ST_READ = 3'h2,
    QPS_ST_SEND = 3'h4
  } qps_st_t;

  typedef logic [1:0] qps_qid_t;

endpackage

// File: hw/qps_mem.sv
/*
 * Small simple dual-port memory holding queued packet tags.
 * Assumes one clock; read data come from a register one cycle after re.
 */
module qps_mem #(
  parameter int DW = 8,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem_q[waddr] <= wdata;
    end
    if (ce && re) begin
      rdata <= mem_q[raddr];
    end
  end

endmodule

// File: hw/qps_top.sv
/*
 * Packet priority classifier with four egress queues and a scheduler.
 * Assumes packets arrive as a byte stream with a per-packet tag handle,
 * packet data held outside; software on an Avalon-MM slave port.
 */
`include "qps_consts.svh"

module qps_top
  import qps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [7:0] in_data,
  input wire logic [3:0] in_port,
  input wire logic [7:0] in_tag,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_tag,
  output logic [1:0] out_queue
);

  // ========================================================================
  // functions
  // next non-empty queue after cur, walking upward from cur+1 cyclically
  function automatic qps_qid_t qps_next(input qps_qid_t cur,
                                       input logic [3:0] ne);
    qps_qid_t r;
    qps_qid_t c;
    r = cur;
    for (int i = `QPS_NQ; i >= 1; i--) begin
      c = qps_qid_t'(cur + qps_qid_t'(i));
      if (ne[c]) begin
        r = c;
      end
    end
    return r;
  endfunction

  // a arrived before b; in-flight count never exceeds 64, half the seq range
  function automatic logic qps_older(input logic [6:0] a,
                                    input logic [6:0] b);
    logic [6:0] d;
    d = 7'(a - b);
    return d[6];
  endfunction

  // ========================================================================
  // configuration and bus slave
  logic [1:0] cls_q, cls_d;
  logic [1:0] sch_q, sch_d;
  logic [15:0] qmap_q, qmap_d;
  logic [15:0] wgt_q, wgt_d;
  logic [9:0] dsen_q, dsen_d;
  logic [3:0] ppri_q [0:`QPS_NPORT-1];
  logic [3:0] ppri_d [0:`QPS_NPORT-1];
  logic [2:0] dmap_q [0:`QPS_NDSCP-1];
  logic [2:0] dmap_d [0:`QPS_NDSCP-1];
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [4:0] qcnt [0:`QPS_NQ-1];

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;

  always_comb begin
    cls_d = cls_q;
    sch_d = sch_q;
    qmap_d = qmap_q;
    wgt_d = wgt_q;
    dsen_d = dsen_q;
    ppri_d = ppri_q;
    dmap_d = dmap_q;
    rdata_d = rdata_q;
    // one wait state: reads decode in the first cycle, writes in the second; both answer in the second
    ack_d = (avs_read | avs_write) & ~ack_q;
    if (avs_read && !ack_q) begin
      rdata_d = 32'h0;
      if (avs_address == `QPS_OFF_CTRL) begin
        rdata_d[3:0] = {sch_q, cls_q};
      end else if (avs_address == `QPS_OFF_QMAP) begin
        rdata_d[15:0] = qmap_q;
      end else if (avs_address == `QPS_OFF_WGT) begin
        rdata_d[15:0] = wgt_q;
      end else if (avs_address == `QPS_OFF_DSEN) begin
        rdata_d[9:0] = dsen_q;
      end else if (avs_address == `QPS_OFF_STAT) begin
        rdata_d[19:0] = {qcnt[3], qcnt[2], qcnt[1], qcnt[0]};
      end else if (avs_address >= `QPS_OFF_PPRI &&
                   avs_address < `QPS_OFF_PPRI + 8'(`QPS_NPORT)) begin
        rdata_d[3:0] = ppri_q[4'(avs_address - `QPS_OFF_PPRI)];
      end else if (avs_address[7:6] == `QPS_DMAP_SEL) begin
        rdata_d[2:0] = dmap_q[avs_address[5:0]];
      end
    end
    if (avs_write && ack_q) begin
      if (avs_address == `QPS_OFF_CTRL) begin
        cls_d = avs_writedata[`QPS_CTRL_CLS];
        sch_d = avs_writedata[`QPS_CTRL_SCH];
      end else if (avs_address == `QPS_OFF_QMAP) begin
        qmap_d = avs_writedata[15:0];
      end else if (avs_address == `QPS_OFF_WGT) begin
        wgt_d = avs_writedata[15:0];
      end else if (avs_address == `QPS_OFF_DSEN) begin
        dsen_d = avs_writedata[9:0];
      end else if (avs_address >= `QPS_OFF_PPRI &&
                   avs_address < `QPS_OFF_PPRI + 8'(`QPS_NPORT)) begin
        ppri_d[4'(avs_address - `QPS_OFF_PPRI)] = avs_writedata[3:0];
      end else if (avs_address[7:6] == `QPS_DMAP_SEL) begin
        dmap_d[avs_address[5:0]] = avs_writedata[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cls_q <= `QPS_RST_CLS;
      sch_q <= `QPS_RST_SCH;
      qmap_q <= `QPS_RST_QMAP;
      wgt_q <= `QPS_RST_WGT;
      dsen_q <= `QPS_RST_DSEN;
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      for (int i = 0; i < `QPS_NPORT; i++) begin
        ppri_q[i] <= 4'h0;
      end
      for (int i = 0; i < `QPS_NDSCP; i++) begin
        dmap_q[i] <= 3'h0;
      end
    end else if (ce) begin
      cls_q <= cls_d;
      sch_q <= sch_d;
      qmap_q <= qmap_d;
      wgt_q <= wgt_d;
      dsen_q <= dsen_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ppri_q <= ppri_d;
      dmap_q <= dmap_d;
    end
  end

  // ========================================================================
  // header parser
  logic [4:0] bcnt_q, bcnt_d;
  logic [7:0] prev_q, prev_d;
  logic tagged_q, tagged_d;
  logic [2:0] pcp_q, pcp_d;
  logic ipv4_q, ipv4_d;
  logic has_tos_q, has_tos_d;
  logic [7:0] tos_q, tos_d;
  logic beat;
  logic [4:0] idx;

  assign beat = ce & in_valid & in_ready;
  assign idx = in_sop ? 5'h0 : bcnt_q;

  always_comb begin
    bcnt_d = bcnt_q;
    prev_d = prev_q;
    tagged_d = tagged_q;
    pcp_d = pcp_q;
    ipv4_d = ipv4_q;
    has_tos_d = has_tos_q;
    tos_d = tos_q;
    if (beat) begin
      if (in_sop) begin
        tagged_d = 1'b0;
        ipv4_d = 1'b0;
        has_tos_d = 1'b0;
      end
      bcnt_d = (idx == `QPS_B_LAST) ? idx : 5'(idx + 5'h1);
      prev_d = in_data;
      if (idx == `QPS_B_ETYPE && {prev_q, in_data} == `QPS_ET_VLAN) begin
        tagged_d = 1'b1;
      end
      if (idx == `QPS_B_ETYPE && {prev_q, in_data} == `QPS_ET_IPV4) begin
        ipv4_d = 1'b1;
      end
      if (idx == `QPS_B_PCP && tagged_q) begin
        pcp_d = in_data[`QPS_PCP];
      end
      if (idx == `QPS_B_ETYPE_T && tagged_q &&
          {prev_q, in_data} == `QPS_ET_IPV4) begin
        ipv4_d = 1'b1;
      end
      // whole service octet kept; only its upper six bits are used
      if (ipv4_q && idx == (tagged_q ? `QPS_B_TOS_T : `QPS_B_TOS)) begin
        tos_d = in_data;
        has_tos_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bcnt_q <= 5'h0;
      prev_q <= 8'h0;
      tagged_q <= 1'b0;
      pcp_q <= 3'h0;
      ipv4_q <= 1'b0;
      has_tos_q <= 1'b0;
      tos_q <= 8'h0;
    end else if (ce) begin
      bcnt_q <= bcnt_d;
      prev_q <= prev_d;
      tagged_q <= tagged_d;
      pcp_q <= pcp_d;
      ipv4_q <= ipv4_d;
      has_tos_q <= has_tos_d;
      tos_q <= tos_d;
    end
  end

  // ========================================================================
  // classification, decided on the last byte of the packet
  logic [2:0] prio;
  qps_qid_t qsel;
  logic port_ok;
  logic [3:0] pidx;
  logic [5:0] dscp;

  assign pidx = 4'(in_port - 4'h1);
  assign port_ok = in_port >= 4'h1 && in_port <= 4'(`QPS_NPORT);
  // precedence lands in the top three code point bits; must_be_zero_bit
  // at bit 0 is never looked at
  assign dscp = tos_q[`QPS_TOS_DSCP];

  always_comb begin
    prio = 3'h0;
    case (qps_cls_t'(cls_q))
      QPS_CLS_TAG: begin
        if (tagged_q) begin
          prio = pcp_q;
        end
      end
      QPS_CLS_DSCP: begin
        if (has_tos_q && port_ok && dsen_q[pidx]) begin
          prio = dmap_q[dscp];
        end
      end
      QPS_CLS_PORT: begin
        if (port_ok && ppri_q[pidx][`QPS_PPRI_EN]) begin
          prio = ppri_q[pidx][`QPS_PPRI_LVL];
        end
      end
      default: begin
        prio = 3'h0;
      end
    endcase
    // level 7 is most important; the table ranks it into a queue
    qsel = qps_qid_t'(qmap_q[{prio, 1'b0} +: 2]);
  end

  // ========================================================================
  // queues and egress scheduler
  logic [4:0] wp_q [0:`QPS_NQ-1];
  logic [4:0] wp_d [0:`QPS_NQ-1];
  logic [4:0] rp_q [0:`QPS_NQ-1];
  logic [4:0] rp_d [0:`QPS_NQ-1];
  logic [6:0] seq_q [0:`QPS_NQ*16-1];
  logic [6:0] seq_d [0:`QPS_NQ*16-1];
  logic [6:0] arr_q, arr_d;
  qps_st_t st_q, st_d;
  qps_qid_t wcur_q, wcur_d;
  logic [3:0] wcnt_q, wcnt_d;
  logic ov_q, ov_d;
  logic [7:0] otag_q, otag_d;
  qps_qid_t oq_q, oq_d;
  logic [3:0] nempty;
  logic enq;
  logic rd_en;
  qps_qid_t pick;
  logic [3:0] w;
  logic [7:0] mem_rdata;

  always_comb begin
    for (int i = 0; i < `QPS_NQ; i++) begin
      qcnt[i] = 5'(wp_q[i] - rp_q[i]);
      nempty[i] = qcnt[i] != 5'h0;
    end
  end

  assign in_ready = !(in_eop && qcnt[qsel] == `QPS_QDEPTH);
  assign enq = beat & in_eop;
  assign out_valid = ov_q;
  assign out_tag = otag_q;
  assign out_queue = oq_q;
  assign w = wgt_q[{wcur_q, 2'h0} +: 4];

  always_comb begin
    pick = 2'h0;
    case (qps_sch_t'(sch_q))
      QPS_SCH_FCFS: begin
        // oldest head of line over all queues, whatever its rank
        pick = qps_next(2'h3, nempty);
        for (int i = 0; i < `QPS_NQ; i++) begin
          if (nempty[i] && qps_older(seq_q[{2'(i), rp_q[i][3:0]}],
                                     seq_q[{pick, rp_q[pick][3:0]}])) begin
            pick = 2'(i);
          end
        end
      end
      QPS_SCH_STRICT: begin
        pick = qps_next(2'h3, nempty);
      end
      default: begin
        // a zero weight still serves one packet per turn
        if (nempty[wcur_q] && wcnt_q < w) begin
          pick = wcur_q;
        end else begin
          pick = qps_next(wcur_q, nempty);
        end
      end
    endcase
  end

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    seq_d = seq_q;
    arr_d = arr_q;
    st_d = st_q;
    wcur_d = wcur_q;
    wcnt_d = wcnt_q;
    ov_d = ov_q;
    otag_d = otag_q;
    oq_d = oq_q;
    rd_en = 1'b0;
    if (enq) begin
      seq_d[{qsel, wp_q[qsel][3:0]}] = arr_q;
      wp_d[qsel] = 5'(wp_q[qsel] + 5'h1);
      arr_d = 7'(arr_q + 7'h1);
    end
    case (st_q)
      QPS_ST_PICK: begin
        if (nempty != 4'h0) begin
          rd_en = 1'b1;
          rp_d[pick] = 5'(rp_q[pick] + 5'h1);
          oq_d = pick;
          wcnt_d = (pick == wcur_q) ? 4'(wcnt_q + 4'h1) : 4'h1;
          wcur_d = pick;
          st_d = QPS_ST_READ;
        end
      end
      QPS_ST_READ: begin
        otag_d = mem_rdata;
        ov_d = 1'b1;
        st_d = QPS_ST_SEND;
      end
      QPS_ST_SEND: begin
        if (out_ready) begin
          ov_d = 1'b0;
          st_d = QPS_ST_PICK;
        end
      end
      default: begin
        st_d = QPS_ST_PICK;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `QPS_NQ; i++) begin
        wp_q[i] <= 5'h0;
        rp_q[i] <= 5'h0;
      end
      for (int i = 0; i < `QPS_NQ*16; i++) begin
        seq_q[i] <= 7'h0;
      end
      arr_q <= 7'h0;
      st_q <= QPS_ST_PICK;
      wcur_q <= 2'h0;
      wcnt_q <= 4'h0;
      ov_q <= 1'b0;
      otag_q <= 8'h0;
      oq_q <= 2'h0;
    end else if (ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      seq_q <= seq_d;
      arr_q <= arr_d;
      st_q <= st_d;
      wcur_q <= wcur_d;
      wcnt_q <= wcnt_d;
      ov_q <= ov_d;
      otag_q <= otag_d;
      oq_q <= oq_d;
    end
  end

  qps_mem #(
    .DW(`QPS_TAGW),
    .AW(6)
  ) u_tags (
    .clk(clk),
    .ce(ce),
    .we(enq),
    .waddr({qsel, wp_q[qsel][3:0]}),
    .wdata(in_tag),
    .re(rd_en),
    .raddr({pick, rp_q[pick][3:0]}),
    .rdata(mem_rdata)
  );

endmodule

// File: bench/qps_chk.sv
/* qps_chk: port assertions for qps_top.
   assumes one clock domain; bound onto qps_top below. */
`include "qps_consts.svh"
module qps_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic in_eop,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_tag,
  input wire logic [1:0] out_queue
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ======
  // register bus
  a_wait_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait without request");
  a_wait_first: assert property ($rose(avs_write) |-> avs_waitrequest)
    else $error("write answered without wait state");
  a_wait_one: assert property (avs_read && avs_waitrequest && ce ##1
    ce && avs_read |-> !avs_waitrequest)
    else $error("read not answered after one wait state");
  a_hole_zero: assert property (avs_read && !avs_waitrequest &&
    (avs_address inside {[8'h05:8'h0F], [8'h1A:8'h3F], [8'h80:8'hFF]})
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_stat_max: assert property (
    avs_read && !avs_waitrequest && avs_address == `QPS_OFF_STAT |->
    avs_readdata[4:0] <= 5'h10 && avs_readdata[9:5] <= 5'h10 &&
    avs_readdata[14:10] <= 5'h10 && avs_readdata[19:15] <= 5'h10 &&
    avs_readdata[31:20] == 12'h000)
    else $error("queue fill out of range");
  // ======
  // packet ports
  a_ready_eop: assert property (!in_ready |-> in_eop)
    else $error("ingress stalled off the last byte");
  a_out_hold: assert property (out_valid && !out_ready && ce |=>
    out_valid && $stable(out_tag) && $stable(out_queue))
    else $error("egress changed before accept");
  a_out_gap: assert property (out_valid && out_ready && ce |=>
    !out_valid [*2])
    else $error("egress faster than one per three cycles");
  a_valid_soon: assert property (
    in_valid && in_ready && in_eop && ce && !out_valid |-> ##[1:5] out_valid)
    else $error("egress idle with a queued packet");
  a_ce_freeze: assert property (!ce |=> $stable(out_valid) &&
    $stable(out_tag) && $stable(out_queue) && $stable(avs_readdata))
    else $error("state moved while clock enable low");
  a_rst_clear: assert property (disable iff (1'b0) srst |=>
    !out_valid && out_tag == 8'h00 && out_queue == 2'h0)
    else $error("egress not cleared by reset");
  c_stall: cover property (out_valid && !out_ready ##1 out_valid);
  c_full: cover property (!in_ready);
  c_stat: cover property (avs_read && !avs_waitrequest &&
    avs_address == `QPS_OFF_STAT);
endmodule

bind qps_top qps_chk i_qps_chk (
  .clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .in_valid(in_valid), .in_ready(in_ready), .in_eop(in_eop),
  .out_valid(out_valid), .out_ready(out_ready), .out_tag(out_tag),
  .out_queue(out_queue)
);

// File: bench/qps_port_model.sv
/* qps_port_model: network ports feeding and draining qps_top.
   assumes send is called just after a rising edge of clk. */
module qps_port_model (
  input wire logic clk,
  input wire logic hold,
  output logic in_valid,
  input wire logic in_ready,
  output logic in_sop,
  output logic in_eop,
  output logic [7:0] in_data,
  output logic [3:0] in_port,
  output logic [7:0] in_tag,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [7:0] out_tag,
  input wire logic [1:0] out_queue
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] got[$];
  initial begin
    {in_valid, in_sop, in_eop, in_data, in_port, in_tag} = '0;
    out_ready = 1'b0;
  end
  // ======
  // egress: random stalls, or none taken while hold is up
  always @(posedge clk) out_ready <= !hold && ($urandom % 3 != 0);
  always @(negedge clk)
    if (out_valid === 1'b1 && out_ready === 1'b1)
      got.push_back({out_tag, out_queue});
  // ======
  // ingress: one byte per accepted beat
  task automatic send(input logic [7:0] b[24], input logic [3:0] p,
    input logic [7:0] t);
    for (int i = 0; i < 24; i++) begin
      in_valid <= 1'b1;
      in_sop <= (i == 0);
      in_eop <= (i == 23);
      in_data <= b[i];
      in_port <= p;
      in_tag <= (i == 23) ? t : ~t;
      // ready is read at the accepting edge itself, pre-edge values
      do @(posedge clk); while (in_ready !== 1'b1);
    end
    // stale values would let a sticky design slip through
    in_valid <= 1'b0;
    in_eop <= 1'b0;
    in_data <= ~b[23];
    in_tag <= ~t;
    // idle cycle, so a following send never rewrites valid in this step
    @(posedge clk);
  endtask
endmodule

// File: bench/qps_tb_top.sv
/* qps_tb_top: qps_top against a queue model of classes and schedules.
   assumes qps_chk bound and qps_port_model at the packet ports. */
module qps_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hold = 1'b1;
  logic ce = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, in_valid, in_ready, in_sop, in_eop, out_valid;
  logic out_ready;
  logic [7:0] in_data, in_tag, out_tag;
  logic [3:0] in_port;
  logic [1:0] out_queue;
  int n_errors = 0;
  int num_checks = 0;
  int cls, sch, qmap, wgt, dsen, cur, cnt, slot;
  int dmap[64];
  int pp[10];
  int mq[$];
  logic [7:0] ra[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h7F,
    8'h30};
  logic [31:0] rv[8] = '{32'h8, 32'h5AF, 32'h1248, 32'h3FF, 32'h0, 32'h0,
    32'h0, 32'h0};

  always #25 clk = ~clk;

  qps_top i_qps_top (
    .clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
    .in_ready(in_ready), .in_sop(in_sop), .in_eop(in_eop),
    .in_data(in_data), .in_port(in_port), .in_tag(in_tag),
    .out_valid(out_valid), .out_ready(out_ready), .out_tag(out_tag),
    .out_queue(out_queue)
  );
  qps_port_model i_qps_port_model (
    .clk(clk), .hold(hold), .in_valid(in_valid), .in_ready(in_ready),
    .in_sop(in_sop), .in_eop(in_eop), .in_data(in_data),
    .in_port(in_port), .in_tag(in_tag), .out_valid(out_valid),
    .out_ready(out_ready), .out_tag(out_tag), .out_queue(out_queue)
  );

  // ======
  // reporting
  task automatic results();
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_reg(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pkt(string n, logic [9:0] e, logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h/%0d seen %h/%0d", n, e[9:2], e[1:0],
        g[9:2], g[1:0]);
    end
  endtask
  // ======
  // register bus master
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    // waitrequest and read data are taken at the same rising edge
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk_reg(n, e, q);
  endtask
  // ======
  // model of classification and scheduling
  function automatic int prio(logic [7:0] b[24], int p);
    logic tg, ip;
    logic [7:0] tos;
    tg = {b[12], b[13]} == 16'h8100;
    ip = tg ? {b[16], b[17]} == 16'h0800 : {b[12], b[13]} == 16'h0800;
    tos = tg ? b[19] : b[15];
    if (cls == 0) return tg ? int'(b[14][7:5]) : 0;
    if (p < 1 || p > 10) return 0;
    if (cls == 1) return (ip && dsen[p-1]) ? dmap[tos[7:2]] : 0;
    if (cls == 2) return pp[p-1][3] ? pp[p-1][2:0] : 0;
    return 0;
  endfunction
  function automatic bit has(int q);
    foreach (mq[i]) if (mq[i] % 4 == q) return 1'b1;
    return 1'b0;
  endfunction
  function automatic int pick();
    int want, w, k;
    want = -1;
    if (sch == 1) begin
      want = 3;
      foreach (mq[i]) if (mq[i] % 4 < want) want = mq[i] % 4;
    end else if (sch >= 2) begin
      w = (wgt >> (4 * cur)) % 16;
      if (!has(cur) || cnt >= (w ? w : 1)) begin
        cnt = 0;
        do cur = (cur + 1) % 4; while (!has(cur));
      end
      cnt++;
      want = cur;
    end
    foreach (mq[i]) if (want < 0 || mq[i] % 4 == want) begin
      k = mq[i];
      mq.delete(i);
      return k;
    end
    return -1;
  endfunction
  // ======
  // scenario steps
  task automatic rst();
    srst <= 1'b1;
    hold <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    cur = 0;
    cnt = 0;
    slot = -1;
    mq.delete();
  endtask
  task automatic cfg(int c, int s, bit full);
    rst();
    cls = c;
    sch = s;
    qmap = full ? 0 : $urandom % 65536;
    wgt = (c % 2) ? $urandom % 65536 : 32'h1248;
    dsen = $urandom % 1024;
    wr(8'h00, 32'(c + 4 * s));
    wr(8'h01, 32'(qmap));
    wr(8'h02, 32'(wgt));
    wr(8'h03, 32'(dsen));
    wr(8'h04, 32'hFFFFFFFF);
    foreach (pp[i]) begin
      pp[i] = $urandom % 16;
      wr(8'(16 + i), 32'(pp[i]));
    end
    foreach (dmap[i]) begin
      dmap[i] = $urandom % 8;
      wr(8'(64 + i), 32'(dmap[i]));
    end
  endtask
  task automatic load(int n);
    logic [7:0] b[24];
    int p, t, k;
    repeat (n) begin
      foreach (b[i]) b[i] = 8'($urandom);
      k = $urandom % 4;
      if (k < 2) {b[12], b[13]} = 16'h8100;
      if (k == 1) {b[16], b[17]} = 16'h0800;
      if (k == 2) {b[12], b[13]} = 16'h0800;
      p = $urandom % 12;
      t = $urandom % 256;
      i_qps_port_model.send(b, 4'(p), 8'(t));
      mq.push_back(t * 4 + (qmap >> (2 * prio(b, p))) % 4);
      if (slot < 0) slot = pick();
    end
  endtask
  task automatic stat();
    int e;
    e = 0;
    foreach (mq[i]) e += 1 << (5 * (mq[i] % 4));
    rd("queue fill", 8'h04, e);
  endtask
  task automatic drain(int n);
    logic [9:0] g;
    hold <= 1'b0;
    repeat (n) begin
      while (i_qps_port_model.got.size() == 0) @(posedge clk);
      g = i_qps_port_model.got.pop_front();
      chk_pkt("egress", 10'(slot), g);
      slot = mq.size() ? pick() : -1;
    end
    hold <= 1'b1;
  endtask
  // ======
  // main sequence
  initial begin
    void'($urandom(7));
    rst();
    foreach (ra[i]) rd("reset value", ra[i], rv[i]);
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 4; c++) begin
        cfg(c, s, 1'b0);
        load(12);
        // frozen cycles must leave queues and egress untouched
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        stat();
        drain(12);
      end
    // one queue past its depth: last byte must wait for room
    cfg(0, 1, 1'b1);
    load(17);
    stat();
    fork
      load(1);
      begin
        repeat (60) @(posedge clk);
        chk_reg("ingress ready", 32'h0, 32'(in_ready));
        drain(18);
      end
    join
    results();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
